// ==== inc/sfi_pkg.sv ====
package sfi_pkg;
  // byte, header and address layout
  localparam int BYTE_W = 8;
  localparam int CNT_W = 3;
  localparam int ADDR_W = 24;
  localparam int HDR_BYTES = 4;
  localparam int PAGE_BYTES = 256;
  // modelled array: the full 24-bit space is far too big to hold
  localparam int MODEL_AW = 12;
  localparam int SECTOR_AW = 18;
  // command opcodes
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] PAGE_WRITE_CMD = 8'h02;
  localparam logic [7:0] DATA_READ_CMD = 8'h03;
  localparam logic [7:0] WRITE_LOCK_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] WRITE_UNLOCK_CMD = 8'h06;
  localparam logic [7:0] REGION_WIPE_CMD_A = 8'h20;
  localparam logic [7:0] REGION_WIPE_CMD_B = 8'hd8;
  localparam logic [7:0] CHIP_WIPE_CMD_A = 8'hc7;
  localparam logic [7:0] CHIP_WIPE_CMD_B = 8'h60;
  // status byte layout
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam int LEVEL_LSB = 2;
  localparam int LEVEL_W = 3;
  localparam logic [2:0] LEVEL_ALL = 3'h7;
  localparam int LEVEL_SHIFT = 17;
  // device pin sampler layout
  localparam int SY_GUARD = 0;
  localparam int SY_HOLD = 1;
  localparam int SY_SI = 2;
  localparam int SY_CS = 3;
  localparam int SY_SCK = 4;
  localparam int SY_PAR = 5;
  localparam int SY_PB = 6;
  localparam int SY_W = 14;
  localparam logic [13:0] SY_IDLE = 14'h000b;
  // link timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCK_PERIOD_NS = 320;
  localparam int SCK_HALF_CLKS = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int MIN_HALF_CLKS = 4;
endpackage : sfi_pkg

// ==== inc/sfi_link_if.sv ====
`timescale 1ns/1ps
interface sfi_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe_n;
  logic hold_n;
  logic write_guard_n;
  logic par_mode;
  logic [7:0] pb_dev;
  logic pb_dev_oe_n;
  logic [7:0] pb_host;
  logic pb_host_oe_n;
  logic so_line;
  logic [7:0] parallel_bus;
  // released lines read as ones
  assign so_line = so_oe_n ? 1'h1 : so;
  assign parallel_bus = !pb_dev_oe_n ? pb_dev : (!pb_host_oe_n ? pb_host : 8'hff);
  modport dev (
    input sck, cs_n, si, hold_n, write_guard_n, par_mode, parallel_bus,
    output so, so_oe_n, pb_dev, pb_dev_oe_n
  );
  modport host (
    output sck, cs_n, si, hold_n, write_guard_n, par_mode, pb_host, pb_host_oe_n,
    input so_line, parallel_bus
  );
endinterface : sfi_link_if

// ==== rtl/sfi_device.sv ====
`timescale 1ns/1ps
// Summary of operation
// - serial output changes after sck falling edge
// - serial input sampled on sck rising edge
// - parallel bytes: in on rise, out on fall
// - chip select high deselects, output released
// - no command before first select fall
// - pause releases output, keeps transfer state
// - pause counts only while select low
// - guard low blocks writes to protected region
// - clock modes 0 and 3 only
// - master idles clock at mode level
// - everything moves in whole bytes
// - unlock first, then header plus data
// - page write takes 1 to 256 bytes
// - programming only clears bits
// - wipes set sector or array to ones
// - master wipes before programming
// - unlock sets latch, completions clear it
// - busy flag shows operation in progress
// - serial writes need pulse count multiple of eight
// - level bits pick read-only region
module sfi_device #(
  parameter int MEM_AW = sfi_pkg::MODEL_AW,
  parameter int SECT_AW = sfi_pkg::SECTOR_AW
) (
  // clock, reset, freeze
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic en_in,
  // serial link
  sfi_link_if.dev link,
  // status for local logic
  output logic busy_out,
  output logic latch_out,
  output logic [sfi_pkg::LEVEL_W-1:0] level_out
);

  // page walk indexes the low byte of the walk counter
  if (MEM_AW < 8 || MEM_AW > sfi_pkg::ADDR_W || SECT_AW < 8) begin : g_bad_size
    $error("sfi_device: unsupported memory or sector width");
  end

  localparam int SB = (SECT_AW < MEM_AW) ? SECT_AW : MEM_AW;
  localparam logic [MEM_AW-1:0] SMASK = MEM_AW'((64'h1 << SB) - 64'h1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_PROG = 3'h2,
    ST_WIPE = 3'h4
  } sfi_dst_t;

  typedef struct packed {
    logic [sfi_pkg::SY_W-1:0] sy1;
    logic [sfi_pkg::SY_W-1:0] sy2;
    logic sck_d;
    logic cs_d;
    logic armed;
    logic latch;
    logic [sfi_pkg::LEVEL_W-1:0] level;
    sfi_dst_t st;
    logic [sfi_pkg::CNT_W-1:0] bit_cnt;
    logic [sfi_pkg::CNT_W-1:0] byte_cnt;
    logic [7:0] cmd;
    logic [7:0] rx;
    logic [7:0] stat_in;
    logic [sfi_pkg::ADDR_W-1:0] addr;
    logic [7:0] tx;
    logic tx_act;
    logic so;
    logic so_en;
    logic [7:0] pb;
    logic pb_en;
    logic [sfi_pkg::PAGE_BYTES-1:0] mask;
    logic [MEM_AW-1:0] wk;
    logic [MEM_AW-1:0] wk_end;
  } sfi_dstate_t;

  localparam sfi_dstate_t RST = '{
    sy1: sfi_pkg::SY_IDLE,
    sy2: sfi_pkg::SY_IDLE,
    cs_d: 1'h1,
    st: ST_IDLE,
    default: '0
  };

  sfi_dstate_t r;
  sfi_dstate_t n;
  logic [7:0] mem [2**MEM_AW];
  logic [7:0] pbuf [sfi_pkg::PAGE_BYTES];
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic buf_we;
  logic [7:0] buf_wa;
  logic [7:0] buf_wd;
  logic cs;
  logic hold;
  logic par;
  logic live;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic byte_done;
  logic out_phase;
  logic [7:0] rx_byte;
  logic [7:0] src;
  logic [7:0] status;

  // true when the address lies in the region the level bits guard
  function automatic logic sfi_locked(input logic [sfi_pkg::ADDR_W-1:0] a,
      input logic [sfi_pkg::LEVEL_W-1:0] lvl);
    int sh;
    sh = sfi_pkg::LEVEL_SHIFT + int'(lvl);
    return (lvl == sfi_pkg::LEVEL_ALL) ||
        (lvl != '0 && (a >> sh) == ({sfi_pkg::ADDR_W{1'h1}} >> sh));
  endfunction : sfi_locked

  // whole transfer engine: pin sampling, framing, shifting, walks
  always_comb begin
    n = r;
    mem_we = 1'h0;
    mem_wa = '0;
    mem_wd = 8'hff;
    buf_we = 1'h0;
    buf_wa = 8'h00;
    buf_wd = 8'h00;
    byte_done = 1'h0;
    rx_byte = 8'h00;
    cs = r.sy2[sfi_pkg::SY_CS];
    hold = r.sy2[sfi_pkg::SY_HOLD];
    par = r.sy2[sfi_pkg::SY_PAR];
    cs_fall = r.cs_d & ~cs;
    cs_rise = ~r.cs_d & cs;
    // pause only bites while selected; edges seen during it are dropped
    live = ~cs & hold & r.armed;
    // same edge roles in mode 0 and mode 3
    rise = ~r.sck_d & r.sy2[sfi_pkg::SY_SCK] & live;
    fall = r.sck_d & ~r.sy2[sfi_pkg::SY_SCK] & live;
    status = 8'h00;
    status[sfi_pkg::BUSY_BIT] = (r.st != ST_IDLE);
    status[sfi_pkg::LATCH_BIT] = r.latch;
    status[sfi_pkg::LEVEL_LSB +: sfi_pkg::LEVEL_W] = r.level;
    out_phase = (r.cmd == sfi_pkg::DATA_READ_CMD && r.byte_cnt == 3'h4) ||
        (r.cmd == sfi_pkg::STATUS_READ_CMD && r.byte_cnt != 3'h0);
    src = (r.cmd == sfi_pkg::DATA_READ_CMD) ? mem[r.addr[MEM_AW-1:0]] : status;
    if (en_in) begin
      // pins pass two flops before anything looks at them
      n.sy1 = {link.parallel_bus, link.par_mode, link.sck, link.cs_n, link.si,
          link.hold_n, link.write_guard_n};
      n.sy2 = r.sy1;
      n.sck_d = r.sy2[sfi_pkg::SY_SCK];
      n.cs_d = cs;
      // a new frame starts clean; the power-up lockout ends here
      if (cs_fall) begin
        n.armed = 1'h1;
        n.bit_cnt = 3'h0;
        n.byte_cnt = 3'h0;
        n.cmd = 8'h00;
        n.tx_act = 1'h0;
      end
      // input capture
      if (rise) begin
        if (par) begin
          byte_done = 1'h1;
          rx_byte = r.sy2[sfi_pkg::SY_PB +: 8];
        end else begin
          rx_byte = {r.rx[6:0], r.sy2[sfi_pkg::SY_SI]};
          n.rx = rx_byte;
          n.bit_cnt = r.bit_cnt + 3'h1;
          byte_done = (r.bit_cnt == 3'h7);
        end
      end
      // byte sorting: opcode, three address bytes, then data
      if (byte_done) begin
        if (r.byte_cnt != 3'h4) begin
          n.byte_cnt = r.byte_cnt + 3'h1;
        end
        case (r.byte_cnt)
          3'h0: begin
            n.cmd = rx_byte;
            if (r.st == ST_IDLE) begin
              n.mask = '0;
            end
          end
          3'h1: begin
            n.addr[23:16] = rx_byte;
            n.stat_in = rx_byte;
          end
          3'h2: n.addr[15:8] = rx_byte;
          3'h3: n.addr[7:0] = rx_byte;
          default: begin
            // page data wraps within its page; the last write to an offset wins
            if (r.cmd == sfi_pkg::PAGE_WRITE_CMD && r.st == ST_IDLE) begin
              buf_we = 1'h1;
              buf_wa = r.addr[7:0];
              buf_wd = rx_byte;
              n.mask[r.addr[7:0]] = 1'h1;
              n.addr[7:0] = r.addr[7:0] + 8'h01;
            end
          end
        endcase
      end
      // output launch: new bit or byte after each falling edge
      if (fall && out_phase) begin
        if (r.bit_cnt == 3'h0) begin
          n.tx = {src[6:0], 1'h0};
          n.so = src[7];
          n.pb = src;
          n.tx_act = 1'h1;
          if (r.cmd == sfi_pkg::DATA_READ_CMD) begin
            n.addr = r.addr + 24'h000001;
          end
        end else begin
          n.tx = {r.tx[6:0], 1'h0};
          n.so = r.tx[7];
        end
      end
      // drivers let go while deselected or paused
      n.so_en = ~cs & hold & n.tx_act & ~par;
      n.pb_en = ~cs & hold & n.tx_act & par;
      // execution at frame end, only on whole bytes and when idle
      if (cs_rise && r.armed && r.st == ST_IDLE && r.bit_cnt == 3'h0 && r.byte_cnt != 3'h0) begin
        case (r.cmd)
          sfi_pkg::WRITE_UNLOCK_CMD: n.latch = 1'h1;
          sfi_pkg::WRITE_LOCK_CMD: n.latch = 1'h0;
          sfi_pkg::STATUS_WRITE_CMD: begin
            if (r.latch && r.byte_cnt >= 3'h2) begin
              n.level = r.stat_in[sfi_pkg::LEVEL_LSB +: sfi_pkg::LEVEL_W];
              n.latch = 1'h0;
            end
          end
          sfi_pkg::PAGE_WRITE_CMD: begin
            if (r.latch && r.byte_cnt == 3'h4 && r.mask != '0 &&
                !(~r.sy2[sfi_pkg::SY_GUARD] && sfi_locked(r.addr, r.level))) begin
              n.st = ST_PROG;
              n.wk = r.addr[MEM_AW-1:0] & ~MEM_AW'(sfi_pkg::PAGE_BYTES - 1); // page base, any MEM_AW
            end
          end
          sfi_pkg::REGION_WIPE_CMD_A, sfi_pkg::REGION_WIPE_CMD_B: begin
            if (r.latch && r.byte_cnt == 3'h4 &&
                !(~r.sy2[sfi_pkg::SY_GUARD] && sfi_locked(r.addr, r.level))) begin
              n.st = ST_WIPE;
              n.wk = r.addr[MEM_AW-1:0] & ~SMASK;
              n.wk_end = r.addr[MEM_AW-1:0] | SMASK;
            end
          end
          sfi_pkg::CHIP_WIPE_CMD_A, sfi_pkg::CHIP_WIPE_CMD_B: begin
            if (r.latch && !(~r.sy2[sfi_pkg::SY_GUARD] && r.level != '0)) begin
              n.st = ST_WIPE;
              n.wk = '0;
              n.wk_end = '1;
            end
          end
          default: ;
        endcase
      end
      // array walks, one byte a cycle, run while the link does other things
      case (r.st)
        ST_PROG: begin
          mem_wa = r.wk;
          mem_wd = mem[r.wk] & pbuf[r.wk[7:0]];
          mem_we = r.mask[r.wk[7:0]];
          n.wk = r.wk + MEM_AW'(1);
          if (r.wk[7:0] == 8'hff) begin
            n.st = ST_IDLE;
            n.latch = 1'h0;
          end
        end
        ST_WIPE: begin
          mem_we = 1'h1;
          mem_wa = r.wk;
          mem_wd = 8'hff;
          n.wk = r.wk + MEM_AW'(1);
          if (r.wk == r.wk_end) begin
            n.st = ST_IDLE;
            n.latch = 1'h0;
          end
        end
        ST_IDLE: ;
        default: n.st = ST_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  // storage carries no reset; the array starts erased
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (buf_we) begin
      pbuf[buf_wa] <= buf_wd;
    end
  end

  initial begin
    for (int i = 0; i < 2**MEM_AW; i++) begin
      mem[i] = 8'hff;
    end
  end

  // link and status drivers
  assign link.so = r.so;
  assign link.so_oe_n = ~r.so_en;
  assign link.pb_dev = r.pb;
  assign link.pb_dev_oe_n = ~r.pb_en;
  assign busy_out = (r.st != ST_IDLE);
  assign latch_out = r.latch;
  assign level_out = r.level;

endmodule : sfi_device

// ==== rtl/sfi_host.sv ====
`timescale 1ns/1ps
module sfi_host #(
  parameter int HALF_CLKS = sfi_pkg::SCK_HALF_CLKS,
  parameter bit MODE3 = 1'h0
) (
  // clock, reset, freeze
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic en_in,
  // frame request
  input wire logic start_in,
  input wire logic [8:0] len_in,
  input wire logic [8:0] wr_len_in,
  input wire logic par_in,
  input wire logic pause_in,
  input wire logic write_guard_n_in,
  // byte streams
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic busy_out,
  output logic done_out,
  // serial link
  sfi_link_if.host link
);

  // the far end needs about three cycles to see an edge and answer
  if (HALF_CLKS < sfi_pkg::MIN_HALF_CLKS || HALF_CLKS > 255) begin : g_bad_half
    $error("sfi_host: half period out of range");
  end

  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_LEAD = 7'h02,
    H_LOAD = 7'h04,
    H_LO = 7'h08,
    H_HI = 7'h10,
    H_TAIL = 7'h20,
    H_GAP = 7'h40
  } sfi_hst_t;

  typedef struct packed {
    logic [8:0] sy1;
    logic [8:0] sy2;
    sfi_hst_t st;
    logic [7:0] cnt;
    logic [2:0] bit_cnt;
    logic [8:0] left;
    logic [8:0] idx;
    logic [8:0] wr_len;
    logic [7:0] tx;
    logic [7:0] rx;
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic [1:0] hold_q;
    logic [7:0] pb;
    logic pb_oe_n;
    logic par;
    logic rxv;
    logic [7:0] rxd;
    logic done;
  } sfi_hstate_t;

  localparam sfi_hstate_t RST = '{
    st: H_IDLE,
    sck: MODE3,
    cs_n: 1'h1,
    hold_n: 1'h1,
    hold_q: 2'h3,
    pb_oe_n: 1'h1,
    default: '0
  };

  sfi_hstate_t r;
  sfi_hstate_t n;
  logic frz;
  logic tick;

  // bit sequencer; clock low half, high half, sample at end of high
  always_comb begin
    n = r;
    // stay frozen two cycles past the pause so the far end drives again before we sample
    frz = ~r.cs_n & (pause_in | ~r.hold_n | ~r.hold_q[0] | ~r.hold_q[1]);
    tick = (r.cnt == 8'(HALF_CLKS - 1));
    if (en_in) begin
      n.sy1 = {link.parallel_bus, link.so_line};
      n.sy2 = r.sy1;
      n.hold_n = ~(pause_in & ~r.cs_n);
      n.hold_q = {r.hold_q[0], r.hold_n};
      n.rxv = 1'h0;
      n.done = 1'h0;
      if (r.st == H_IDLE || r.st == H_LOAD) begin
        n.cnt = 8'h00;
      end else if (!frz || r.st == H_GAP) begin
        n.cnt = tick ? 8'h00 : r.cnt + 8'h01;
      end else begin
        n.cnt = 8'h00; // a pause restarts the half, giving a full half after resume
      end
      case (r.st)
        H_IDLE: begin
          n.sck = MODE3;
          // frames are built by the user: unlock, header plus data, wipe first
          if (start_in && len_in != 9'h000) begin
            n.cs_n = 1'h0;
            n.par = par_in;
            n.left = len_in;
            n.wr_len = wr_len_in;
            n.idx = 9'h000;
            n.st = H_LEAD;
          end
        end
        H_LEAD: begin
          if (tick && !frz) begin
            n.st = H_LOAD;
          end
        end
        H_LOAD: begin
          if (tx_valid_in && !frz) begin
            n.tx = tx_data_in;
            n.si = tx_data_in[7];
            n.pb = tx_data_in;
            n.pb_oe_n = ~(r.par && r.idx < r.wr_len);
            n.sck = 1'h0;
            n.bit_cnt = 3'h0;
            n.st = H_LO;
          end
        end
        H_LO: begin
          if (tick && !frz) begin
            n.sck = 1'h1;
            n.st = H_HI;
          end
        end
        H_HI: begin
          if (tick && !frz) begin
            n.rx = {r.rx[6:0], r.sy2[0]};
            if (r.par || r.bit_cnt == 3'h7) begin
              n.rxv = 1'h1;
              n.rxd = r.par ? r.sy2[8:1] : {r.rx[6:0], r.sy2[0]};
              n.idx = r.idx + 9'h001;
              n.left = r.left - 9'h001;
              if (r.left == 9'h001) begin
                n.sck = MODE3;
                n.st = H_TAIL;
              end else begin
                n.st = H_LOAD;
              end
            end else begin
              n.bit_cnt = r.bit_cnt + 3'h1;
              n.tx = {r.tx[6:0], 1'h0};
              n.si = r.tx[6];
              n.sck = 1'h0;
              n.st = H_LO;
            end
          end
        end
        H_TAIL: begin
          if (tick && !frz) begin
            n.cs_n = 1'h1;
            n.pb_oe_n = 1'h1;
            n.done = 1'h1;
            n.st = H_GAP;
          end
        end
        H_GAP: begin
          if (tick) begin
            n.st = H_IDLE;
          end
        end
        default: n.st = H_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  // link and user drivers
  assign link.sck = r.sck;
  assign link.cs_n = r.cs_n;
  assign link.si = r.si;
  assign link.hold_n = r.hold_n;
  assign link.write_guard_n = write_guard_n_in;
  assign link.par_mode = r.par;
  assign link.pb_host = r.pb;
  assign link.pb_host_oe_n = r.pb_oe_n;
  assign tx_ready_out = en_in & (r.st == H_LOAD) & ~frz;
  assign rx_valid_out = r.rxv;
  assign rx_data_out = r.rxd;
  assign busy_out = (r.st != H_IDLE);
  assign done_out = r.done;

endmodule : sfi_host

// ==== tb/sfi_link_props.sv ====
`timescale 1ns/1ps
// watches the wires between the two ends
module sfi_link_props (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // link wires
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic hold_n,
  input wire logic par_mode,
  input wire logic pb_dev_oe_n,
  input wire logic pb_host_oe_n
);
  logic sck_q;
  logic armed;
  logic [2:0] bits;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // serial rises per frame; parallel frames move a byte per rise, so not counted
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sck_q <= 1'h0;
      armed <= 1'h0;
      bits <= 3'h0;
    end else begin
      sck_q <= sck;
      armed <= armed | !cs_n;
      bits <= cs_n ? 3'h0 : bits + 3'((sck && !sck_q && !par_mode) ? 1 : 0);
    end
  end
  // one cycle of slack over the release latency
  sequence desel_s;
    cs_n [*5];
  endsequence
  sequence paused_s;
    (!hold_n && !cs_n) [*5];
  endsequence
  idle_clock_low_a: assert property (cs_n |-> !sck) else $error("clock not idle low");
  desel_release_a: assert property (desel_s |-> so_oe_n && pb_dev_oe_n) else $error("driving while deselected");
  pause_release_a: assert property (paused_s |-> so_oe_n && pb_dev_oe_n) else $error("driving while paused");
  pause_clock_still_a: assert property (!hold_n && !$past(hold_n) |-> $stable(sck)) else $error("clock moved in pause");
  pause_needs_sel_a: assert property (!hold_n |-> !cs_n) else $error("pause without select");
  si_steady_a: assert property (sck && $past(sck) |-> $stable(si)) else $error("input moved while clock high");
  so_on_fall_a: assert property (!so_oe_n && !$past(so_oe_n) && $changed(so) |-> !sck) else $error("output moved on rise");
  bus_single_a: assert property (!(!pb_dev_oe_n && !pb_host_oe_n)) else $error("bus driven by both");
  par_drive_a: assert property ($fell(pb_dev_oe_n) |-> par_mode && !cs_n) else $error("bus drive outside parallel");
  whole_bytes_a: assert property ($rose(cs_n) |-> bits == 3'h0) else $error("frame not whole bytes");
  armed_first_a: assert property (!armed |-> so_oe_n && pb_dev_oe_n) else $error("output before first select");
endmodule : sfi_link_props

// ==== tb/test_serial_flash_interface.sv ====
`timescale 1ns/1ps
// host user side driven here; the array image is kept in mem
module test_serial_flash_interface;
  localparam int AW = 8;
  logic clk_in = 1'h0;
  logic arst_n_in = 1'h0;
  logic start_in = 1'h0;
  logic par_in = 1'h0;
  logic pause_in = 1'h0;
  logic write_guard_n_in = 1'h1;
  logic tx_valid_in = 1'h0;
  logic [8:0] len_in = 9'h000;
  logic [8:0] wr_len_in = 9'h000;
  logic [7:0] tx_data_in = 8'h00;
  logic tx_ready_out;
  logic rx_valid_out;
  logic busy_out;
  logic done_out;
  logic dev_busy;
  logic dev_latch;
  logic [7:0] rx_data_out;
  logic [2:0] dev_level;
  logic [7:0] rxq[$];
  logic [7:0] mem[256];
  logic [7:0] wipe[4] = '{sfi_pkg::REGION_WIPE_CMD_A, sfi_pkg::REGION_WIPE_CMD_B,
                          sfi_pkg::CHIP_WIPE_CMD_A, sfi_pkg::CHIP_WIPE_CMD_B};
  logic [31:0] seed = 32'h00000d9a;
  int bad_count = 0;
  int checked = 0;
  int dones = 0;
  sfi_link_if link ();
  // both ends face each other; small model keeps wipes short
  sfi_host sfi_host_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .en_in(1'h1), .start_in(start_in),
    .len_in(len_in), .wr_len_in(wr_len_in), .par_in(par_in), .pause_in(pause_in),
    .write_guard_n_in(write_guard_n_in), .tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in),
    .tx_ready_out(tx_ready_out), .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out),
    .busy_out(busy_out), .done_out(done_out), .link(link));
  sfi_device #(.MEM_AW(AW)) sfi_device_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .en_in(1'h1),
    .link(link), .busy_out(dev_busy), .latch_out(dev_latch), .level_out(dev_level));
  sfi_link_props sfi_link_props_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .sck(link.sck),
    .cs_n(link.cs_n), .si(link.si), .so(link.so), .so_oe_n(link.so_oe_n), .hold_n(link.hold_n),
    .par_mode(link.par_mode), .pb_dev_oe_n(link.pb_dev_oe_n), .pb_host_oe_n(link.pb_host_oe_n));
  // 25 MHz
  always #20 clk_in = ~clk_in;
  // returned bytes in order; taken at the falling edge where they are settled
  always @(negedge clk_in) begin
    if (rx_valid_out === 1'h1) rxq.push_back(rx_data_out);
    if (done_out === 1'h1) dones++;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  // status byte: busy bit 0, latch bit 1, level bits 4:2
  function automatic logic [7:0] status_exp(input logic latch, input logic [2:0] lvl);
    return {3'h0, lvl, latch, 1'h0};
  endfunction : status_exp
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic give_up();
    bad_count++;
    $display("[ERR] t=%0t wait ran out got=%h exp=%h", $time, 1'h0, 1'h1);
    complete_run();
  endtask : give_up
  // one frame; entered and left at a falling edge, valid held until taken
  task automatic frame(input logic [7:0] b[$], input logic par, input logic [8:0] wrl);
    int k;
    rxq = {};
    dones = 0;
    start_in = 1'h1;
    len_in = 9'(b.size());
    par_in = par;
    wr_len_in = wrl;
    @(negedge clk_in);
    start_in = 1'h0;
    foreach (b[j]) begin
      tx_valid_in = 1'h1;
      tx_data_in = b[j];
      for (k = 0; k < 300 && tx_ready_out !== 1'h1; k++) @(negedge clk_in);
      if (k == 300) give_up();
      @(negedge clk_in);
    end
    tx_valid_in = 1'h0;
    for (k = 0; k < 300 && busy_out !== 1'h0; k++) @(negedge clk_in);
    if (k == 300) give_up();
    check(8'(dones), 8'h01);
  endtask : frame
  task automatic settle(input logic exp);
    int k;
    check({7'h00, dev_busy}, {7'h00, exp});
    for (k = 0; k < 2000 && dev_busy !== 1'h0; k++) @(negedge clk_in);
    if (k == 2000) give_up();
  endtask : settle
  task automatic stat_chk(input logic [7:0] exp);
    frame({sfi_pkg::STATUS_READ_CMD, 8'h00}, 1'h0, 9'h000);
    check(rxq[1], exp);
  endtask : stat_chk
  task automatic wr_status(input logic [7:0] v);
    frame({sfi_pkg::WRITE_UNLOCK_CMD}, 1'h0, 9'h000);
    frame({sfi_pkg::STATUS_WRITE_CMD, v}, 1'h0, 9'h000);
    stat_chk(v);
  endtask : wr_status
  // ok low means the write must be refused and leave the image alone
  task automatic prog(input logic [7:0] a, input int n, input logic ok);
    logic [7:0] b[$];
    int i;
    b = {sfi_pkg::PAGE_WRITE_CMD, 8'h00, 8'h00, a};
    for (i = 0; i < n; i++) begin
      b.push_back(rnd());
      if (ok) mem[a + i] = mem[a + i] & b[i + 4];
    end
    frame({sfi_pkg::WRITE_UNLOCK_CMD}, 1'h0, 9'h000);
    frame(b, 1'h0, 9'h000);
    settle(ok);
  endtask : prog
  // pause may land mid-byte; the host holds the clock and waits out the release
  task automatic read_chk(input logic [7:0] a, input int n, input logic par, input logic pz);
    logic [7:0] b[$];
    int i;
    b = {sfi_pkg::DATA_READ_CMD, 8'h00, 8'h00, a};
    repeat (n) b.push_back(8'h00);
    fork
      frame(b, par, 9'h004);
      if (pz) begin
        repeat (100) @(negedge clk_in);
        pause_in = 1'h1;
        repeat (30) @(negedge clk_in);
        pause_in = 1'h0;
      end
    join
    for (i = 0; i < n; i++) check(rxq[4 + i], mem[a + i]);
  endtask : read_chk
  initial begin
    int i;
    logic [7:0] a;
    foreach (mem[j]) mem[j] = 8'hff;
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    arst_n_in = 1'h1;
    stat_chk(8'h00);
    frame({sfi_pkg::WRITE_UNLOCK_CMD}, 1'h0, 9'h000);
    check({7'h00, dev_latch}, 8'h01);
    frame({sfi_pkg::WRITE_LOCK_CMD}, 1'h0, 9'h000);
    stat_chk(status_exp(1'h0, 3'h0));
    $display("test latch done");
    prog(8'h00, 256, 1'h1);
    stat_chk(8'h00);
    read_chk(8'h00, 256, 1'h0, 1'h0);
    for (i = 0; i < 6; i++) begin
      a = rnd() & 8'hf0;
      prog(a, 1 + rnd() % 8, 1'h1);
      read_chk(a, 8, i[0], i[1]);
    end
    $display("test program done");
    wr_status(8'h1c);
    check({5'h00, dev_level}, 8'h07);
    write_guard_n_in = 1'h0;
    prog(8'h40, 4, 1'h0);
    stat_chk(status_exp(1'h1, 3'h7));
    read_chk(8'h40, 4, 1'h0, 1'h0);
    write_guard_n_in = 1'h1;
    wr_status(8'h18);
    write_guard_n_in = 1'h0;
    prog(8'h50, 4, 1'h1);
    read_chk(8'h50, 4, 1'h0, 1'h0);
    write_guard_n_in = 1'h1;
    wr_status(8'h00);
    $display("test protect done");
    foreach (wipe[j]) begin
      a = rnd() & 8'hf0;
      prog(a, 8, 1'h1);
      frame({sfi_pkg::WRITE_UNLOCK_CMD}, 1'h0, 9'h000);
      if (j < 2) begin
        frame({wipe[j], 8'h00, 8'h00, a}, 1'h0, 9'h000);
      end else begin
        frame({wipe[j]}, 1'h0, 9'h000);
      end
      settle(1'h1);
      foreach (mem[k]) mem[k] = 8'hff;
      read_chk(a, 8, 1'h0, 1'h0);
      stat_chk(8'h00);
    end
    $display("test wipe done");
    complete_run();
  end
endmodule : test_serial_flash_interface
